/* design/smp_pkg.sv */
// Behaviour
// - completed sequence snapshots configuration to nonvolatile
// - software select drives power-on request from bit5
// - voltage readings in bits 15:4
// - current reading in bits 15:4
// - supply-off flag sticky until power-on request
// - rectifier-off flag from user, load, flags
// - status bit 6 shows oring switch off
// - bit 7 selects high-side current sensing
// - topology register selects resonant mode
// - gain trims scale the three voltage readings
// - setpoint spans zero to 155 percent
// - primary overvoltage threshold from 108.5 percent
// - debounce code delays primary overvoltage flag
// - undervoltage threshold steps of 155/128 percent
// - remote overvoltage threshold from 107.7 percent
package smp_pkg;
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_VS1    = 8'h15;
   localparam logic [7:0] ADDR_VS2    = 8'h16;
   localparam logic [7:0] ADDR_VS3    = 8'h17;
   localparam logic [7:0] ADDR_CS     = 8'h18;
   localparam logic [7:0] ADDR_CSCFG  = 8'h24;
   localparam logic [7:0] ADDR_PON    = 8'h2c;
   localparam logic [7:0] ADDR_SETP   = 8'h31;
   localparam logic [7:0] ADDR_OV1    = 8'h32;
   localparam logic [7:0] ADDR_OV3    = 8'h33;
   localparam logic [7:0] ADDR_UV1    = 8'h34;
   localparam logic [7:0] ADDR_TRIM1  = 8'h38;
   localparam logic [7:0] ADDR_TRIM2  = 8'h39;
   localparam logic [7:0] ADDR_TRIM3  = 8'h3a;
   localparam logic [7:0] ADDR_TOPO   = 8'h40;
   localparam logic [7:0] ADDR_KEY    = 8'h5e;
   localparam logic [7:0] ADDR_TRIG   = 8'h7b;
   localparam logic [7:0] KEY_VAL     = 8'h00;
   localparam logic [7:0] GO_VAL      = 8'h01;
   localparam logic [7:0] TOPO_OTHER  = 8'h00;
   localparam logic [7:0] CFG_RST     = 8'h00;
   localparam int STAT_OFF_BIT   = 7;
   localparam int STAT_ORING_BIT = 6;
   localparam int STAT_SR_BIT    = 3;
   localparam int PON_BIT        = 5;
   localparam int HS_BIT         = 7;
   localparam int OV_LSB         = 3;
   localparam int OV_MSB         = 7;
   localparam int UV_MSB         = 6;
   localparam int RD_LSB         = 4;
   // overvoltage percentages are kept in hundredths of a percent; PCT_FULL is in whole percent
   localparam logic [31:0] OV1_BASE  = 32'd10850;
   localparam logic [31:0] OV3_BASE  = 32'd10770;
   localparam logic [31:0] OV_STEP   = 32'd121;
   localparam logic [31:0] PCT_DEN   = 32'd10000;
   localparam logic [31:0] PCT_FULL  = 32'd155;
   localparam logic [31:0] SET_DEN   = 32'd25500;
   localparam logic [31:0] UV_DEN    = 32'd12800;
   localparam logic [9:0]  TRIM_UNITY = 10'h100;
   localparam int          TRIM_SHIFT = 8;
   localparam logic [11:0] DEB_CYC0 = 12'h001;
   localparam logic [11:0] DEB_CYC1 = 12'h008;
   localparam logic [11:0] DEB_CYC2 = 12'h040;
   localparam logic [11:0] DEB_CYC3 = 12'h200;
   localparam logic [11:0] UV_DEB_CYC = 12'h001;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } smp_req_t;

   typedef struct packed {
      logic [7:0] cs_cfg;
      logic [7:0] pon_ctrl;
      logic [7:0] setpoint;
      logic [7:0] ov1_cfg;
      logic [7:0] ov3_cfg;
      logic [7:0] uv1_cfg;
      logic [7:0] trim1;
      logic [7:0] trim2;
      logic [7:0] trim3;
      logic [7:0] topology;
   } smp_cfg_t;

   typedef enum logic [1:0] {C_IDLE, C_KEY1, C_KEY2, C_ARMED} smp_commit_t;

   function automatic logic [11:0] smp_deb_limit(input logic [1:0] code);
      case (code)
         2'h0:    return DEB_CYC0;
         2'h1:    return DEB_CYC1;
         2'h2:    return DEB_CYC2;
         default: return DEB_CYC3;
      endcase
   endfunction

   // signed trim around unity gain, saturated to 12 bits
   function automatic logic [11:0] smp_trim(input logic [11:0] raw, input logic [7:0] t);
      logic [9:0]  g;
      logic [21:0] p;
      g = TRIM_UNITY + {{2{t[7]}}, t};
      p = {10'h000, raw} * {12'h000, g};
      p = p >> TRIM_SHIFT;
      return (p > 22'h000fff) ? 12'hfff : p[11:0];
   endfunction

   function automatic logic [11:0] smp_scale(input logic [11:0] nom, input logic [31:0] mul,
                                             input logic [31:0] den);
      logic [47:0] p;
      p = {36'h0, nom} * {16'h0000, mul};
      p = p / {16'h0000, den};
      return (p > 48'h000000000fff) ? 12'hfff : p[11:0];
   endfunction
endpackage

/* design/smp_debounce.sv */
`timescale 1ns/1ns
module smp_debounce
   import smp_pkg::*;
#(
   parameter int W = 12
) (
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   input  wire logic         cond_in,
   input  wire logic [W-1:0] limit_in,
   output logic              flag_out
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         flag;
   } smp_deb_t;

   smp_deb_t s_reg;
   smp_deb_t s_next;

   always_comb begin
      s_next = s_reg;
      if (!cond_in) begin
         s_next.cnt  = '0;
         s_next.flag = 1'b0;
      end else begin
         if (s_reg.cnt != '1) begin
            s_next.cnt = s_reg.cnt + 1'b1;
         end
         s_next.flag = (s_next.cnt >= limit_in);
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign flag_out = s_reg.flag;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   property p_deb_drop;
      !cond_in |=> !flag_out;
   endproperty
   a_deb_drop: assert property (p_deb_drop) else $error("flag held without condition");

   property p_deb_fast;
      $rose(flag_out) && limit_in > 12'h001 |-> $past(cond_in);
   endproperty
   a_deb_fast: assert property (p_deb_fast) else $error("flag rose before debounce");
endmodule

/* design/smp_regs.sv */
`timescale 1ns/1ns
module smp_regs
   import smp_pkg::*;
#(
   parameter logic [11:0] NOM_CODE = 12'h800
) (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire smp_req_t    reg_req_in,
   input  wire logic [11:0] primary_voltage_sense_in,
   input  wire logic [11:0] secondary_voltage_sense_in,
   input  wire logic [11:0] remote_voltage_sense_in,
   input  wire logic [11:0] output_current_sense_in,
   input  wire logic        sw_power_on_sel_in,
   input  wire logic        power_on_pin_in,
   input  wire logic        supply_off_in,
   input  wire logic        oring_switch_on_in,
   input  wire logic        sr_user_disabled_in,
   input  wire logic        sr_flag_disable_in,
   input  wire logic [11:0] light_load_limit_in,
   output logic [15:0]      reg_rdata_out,
   output logic             reg_rvalid_out,
   output logic [7:0]       supply_status_out,
   output logic             power_on_request_out,
   output logic             high_side_sense_out,
   output logic             resonant_mode_out,
   output logic [11:0]      setpoint_code_out,
   output logic             primary_ov_flag_out,
   output logic             remote_ov_flag_out,
   output logic             primary_uv_flag_out,
   output logic             nv_write_out,
   output smp_cfg_t         nv_image_out
);
   typedef struct packed {
      smp_cfg_t         cfg;
      logic [3:0][15:0] rdg;
      logic [7:0]       status;
      logic [15:0]      rdata;
      logic             rvalid;
      smp_commit_t      cst;
      logic             nv_wr;
      smp_cfg_t         nv_img;
      logic             pon;
      logic             hs;
      logic             reso;
      logic [11:0]      setp;
      logic [11:0]      ov1_thr;
      logic [11:0]      ov3_thr;
      logic [11:0]      uv1_thr;
      logic             ov1;
      logic             ov3;
      logic             uv1;
   } smp_state_t;

   smp_state_t  s_reg;
   smp_state_t  s_next;
   logic        ov1_deb;
   logic        ov3_deb;
   logic        uv1_deb;
   smp_req_t    rq;

   assign rq = reg_req_in;

   smp_debounce #(.W(12)) u_ov1 (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .cond_in  (s_reg.rdg[0][15:RD_LSB] > s_reg.ov1_thr),
      .limit_in (smp_deb_limit(s_reg.cfg.ov1_cfg[1:0])),
      .flag_out (ov1_deb)
   );

   smp_debounce #(.W(12)) u_ov3 (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .cond_in  (s_reg.rdg[2][15:RD_LSB] > s_reg.ov3_thr),
      .limit_in (smp_deb_limit(s_reg.cfg.ov3_cfg[1:0])),
      .flag_out (ov3_deb)
   );

   smp_debounce #(.W(12)) u_uv1 (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .cond_in  (s_reg.rdg[0][15:RD_LSB] < s_reg.uv1_thr),
      .limit_in (UV_DEB_CYC),
      .flag_out (uv1_deb)
   );

   always_comb begin
      logic pon_n;
      pon_n = 1'b0;
      s_next = s_reg;
      s_next.nv_wr = 1'b0;
      s_next.rvalid = rq.rd;
      // voltage readings are trimmed copies of the converter codes; the current reading is not trimmed
      s_next.rdg[0] = {smp_trim(primary_voltage_sense_in, s_reg.cfg.trim1), 4'h0};
      s_next.rdg[1] = {smp_trim(secondary_voltage_sense_in, s_reg.cfg.trim2), 4'h0};
      s_next.rdg[2] = {smp_trim(remote_voltage_sense_in, s_reg.cfg.trim3), 4'h0};
      s_next.rdg[3] = {output_current_sense_in, 4'h0};
      if (rq.rd) begin
         case (rq.addr)
            ADDR_STATUS: s_next.rdata = {8'h00, s_reg.status};
            ADDR_VS1:    s_next.rdata = s_reg.rdg[0];
            ADDR_VS2:    s_next.rdata = s_reg.rdg[1];
            ADDR_VS3:    s_next.rdata = s_reg.rdg[2];
            ADDR_CS:     s_next.rdata = s_reg.rdg[3];
            default:     s_next.rdata = 16'h0000;
         endcase
      end
      // reading addresses have no write arm, so writes there fall away
      if (rq.wr) begin
         case (rq.addr)
            ADDR_CSCFG: s_next.cfg.cs_cfg   = rq.wdata;
            ADDR_PON:   s_next.cfg.pon_ctrl = rq.wdata;
            ADDR_SETP:  s_next.cfg.setpoint = rq.wdata;
            ADDR_OV1:   s_next.cfg.ov1_cfg  = rq.wdata;
            ADDR_OV3:   s_next.cfg.ov3_cfg  = rq.wdata;
            ADDR_UV1:   s_next.cfg.uv1_cfg  = rq.wdata;
            ADDR_TRIM1: s_next.cfg.trim1    = rq.wdata;
            ADDR_TRIM2: s_next.cfg.trim2    = rq.wdata;
            ADDR_TRIM3: s_next.cfg.trim3    = rq.wdata;
            ADDR_TOPO:  s_next.cfg.topology = rq.wdata;
            default:    s_next.cfg = s_reg.cfg;
         endcase
         // any write that breaks the sequence starts it over
         s_next.cst = C_IDLE;
         case (s_reg.cst)
            C_IDLE: begin
               if (rq.addr == ADDR_KEY && rq.wdata == KEY_VAL) s_next.cst = C_KEY1;
            end
            C_KEY1: begin
               if (rq.addr == ADDR_KEY && rq.wdata == KEY_VAL) s_next.cst = C_KEY2;
            end
            C_KEY2: begin
               if (rq.addr == ADDR_TRIG && rq.wdata == KEY_VAL) s_next.cst = C_ARMED;
               else if (rq.addr == ADDR_KEY && rq.wdata == KEY_VAL) s_next.cst = C_KEY2;
            end
            C_ARMED: begin
               // the host owns the programming wait; no timer here
               if (rq.addr == ADDR_KEY && rq.wdata == GO_VAL) begin
                  s_next.nv_wr  = 1'b1;
                  s_next.nv_img = s_reg.cfg;
               end
            end
            default: s_next.cst = C_IDLE;
         endcase
      end
      pon_n = sw_power_on_sel_in ? s_reg.cfg.pon_ctrl[PON_BIT] : power_on_pin_in;
      s_next.pon = pon_n;
      // set wins over the release by a power-on edge
      s_next.status = 8'h00;
      s_next.status[STAT_OFF_BIT] = supply_off_in |
                                    (s_reg.status[STAT_OFF_BIT] & ~(pon_n & ~s_reg.pon));
      s_next.status[STAT_ORING_BIT] = ~oring_switch_on_in;
      s_next.status[STAT_SR_BIT] = sr_user_disabled_in | sr_flag_disable_in |
                                   (output_current_sense_in < light_load_limit_in);
      s_next.hs   = s_reg.cfg.cs_cfg[HS_BIT];
      s_next.reso = (s_reg.cfg.topology != TOPO_OTHER);
      s_next.setp = smp_scale(NOM_CODE, PCT_FULL * {24'h0, s_reg.cfg.setpoint}, SET_DEN);
      s_next.ov1_thr = smp_scale(NOM_CODE, OV1_BASE + OV_STEP * 32'(s_reg.cfg.ov1_cfg[OV_MSB:OV_LSB]),
                                 PCT_DEN);
      s_next.ov3_thr = smp_scale(NOM_CODE, OV3_BASE + OV_STEP * 32'(s_reg.cfg.ov3_cfg[OV_MSB:OV_LSB]),
                                 PCT_DEN);
      s_next.uv1_thr = smp_scale(NOM_CODE, PCT_FULL * 32'(s_reg.cfg.uv1_cfg[UV_MSB:0]), UV_DEN);
      s_next.ov1 = ov1_deb;
      s_next.ov3 = ov3_deb;
      s_next.uv1 = uv1_deb;
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_reg <= '0;
         s_reg.cfg <= {10{CFG_RST}};
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata_out        = s_reg.rdata;
   assign reg_rvalid_out       = s_reg.rvalid;
   assign supply_status_out    = s_reg.status;
   assign power_on_request_out = s_reg.pon;
   assign high_side_sense_out  = s_reg.hs;
   assign resonant_mode_out    = s_reg.reso;
   assign setpoint_code_out    = s_reg.setp;
   assign primary_ov_flag_out  = s_reg.ov1;
   assign remote_ov_flag_out   = s_reg.ov3;
   assign primary_uv_flag_out  = s_reg.uv1;
   assign nv_write_out         = s_reg.nv_wr;
   assign nv_image_out         = s_reg.nv_img;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   property p_commit_go;
      rq.wr && rq.addr == ADDR_KEY && rq.wdata == GO_VAL && s_reg.cst == C_ARMED
         |=> nv_write_out && nv_image_out == $past(s_reg.cfg);
   endproperty
   a_commit_go: assert property (p_commit_go) else $error("commit did not snapshot");

   property p_commit_seq;
      $rose(nv_write_out) |-> $past(s_reg.cst) == C_ARMED && $past(rq.addr) == ADDR_KEY;
   endproperty
   a_commit_seq: assert property (p_commit_seq) else $error("commit outside sequence");

   property p_pon_sw;
      rq.wr && rq.addr == ADDR_PON && sw_power_on_sel_in ##1 sw_power_on_sel_in && !rq.wr
         |=> power_on_request_out == $past(rq.wdata[PON_BIT], 2);
   endproperty
   a_pon_sw: assert property (p_pon_sw) else $error("power-on request not from control bit");

   property p_rd_vs1;
      rq.rd && rq.addr == ADDR_VS1 |=> reg_rvalid_out && reg_rdata_out[3:0] == 4'h0;
   endproperty
   a_rd_vs1: assert property (p_rd_vs1) else $error("voltage reading low nibble set");

   property p_rd_cs;
      rq.rd && rq.addr == ADDR_CS |=> reg_rdata_out[15:RD_LSB] == $past(output_current_sense_in, 2);
   endproperty
   a_rd_cs: assert property (p_rd_cs) else $error("current reading mismatch");

   property p_off_sticky;
      supply_status_out[STAT_OFF_BIT] && !supply_off_in && !(s_next.pon && !s_reg.pon)
         |=> supply_status_out[STAT_OFF_BIT];
   endproperty
   a_off_sticky: assert property (p_off_sticky) else $error("supply-off flag dropped early");

   property p_off_set;
      supply_off_in |=> supply_status_out[STAT_OFF_BIT];
   endproperty
   a_off_set: assert property (p_off_set) else $error("supply-off flag not set");

   property p_sr_flag;
      sr_user_disabled_in || sr_flag_disable_in |=> supply_status_out[STAT_SR_BIT];
   endproperty
   a_sr_flag: assert property (p_sr_flag) else $error("rectifier-off flag missing");

   property p_oring;
      !oring_switch_on_in ##1 !oring_switch_on_in |=> supply_status_out[STAT_ORING_BIT];
   endproperty
   a_oring: assert property (p_oring) else $error("oring-off flag missing");

   property p_ro_write;
      rq.wr && rq.addr == ADDR_VS1 |=> s_reg.cfg == $past(s_reg.cfg);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("reading write changed config");

   property p_ov1_cause;
      $rose(primary_ov_flag_out) |-> $past(s_reg.rdg[0][15:RD_LSB] > s_reg.ov1_thr, 2);
   endproperty
   a_ov1_cause: assert property (p_ov1_cause) else $error("overvoltage flag without cause");

   property p_ov3_cause;
      $rose(remote_ov_flag_out) |-> $past(s_reg.rdg[2][15:RD_LSB] > s_reg.ov3_thr, 2);
   endproperty
   a_ov3_cause: assert property (p_ov3_cause) else $error("remote overvoltage flag without cause");

   property p_uv1_cause;
      $rose(primary_uv_flag_out) |-> $past(s_reg.rdg[0][15:RD_LSB] < s_reg.uv1_thr, 2);
   endproperty
   a_uv1_cause: assert property (p_uv1_cause) else $error("undervoltage flag without cause");

   property p_pon_pin;
      !sw_power_on_sel_in |=> power_on_request_out == $past(power_on_pin_in);
   endproperty
   a_pon_pin: assert property (p_pon_pin) else $error("power-on request not from pin");

   property p_hs_sel;
      rq.wr && rq.addr == ADDR_CSCFG |-> ##2 high_side_sense_out == $past(rq.wdata[HS_BIT], 2);
   endproperty
   a_hs_sel: assert property (p_hs_sel) else $error("sense side not from config bit");

   property p_reso;
      rq.wr && rq.addr == ADDR_TOPO |-> ##2 resonant_mode_out == ($past(rq.wdata, 2) != TOPO_OTHER);
   endproperty
   a_reso: assert property (p_reso) else $error("topology select not applied");

   // full-scale code must land between 154 and 155 percent of nominal
   property p_setp_full;
      rq.wr && rq.addr == ADDR_SETP && rq.wdata == 8'hff
         |-> ##2 32'(setpoint_code_out) * 32'd100 > 32'(NOM_CODE) * (PCT_FULL - 32'd1) &&
                 32'(setpoint_code_out) * 32'd100 <= 32'(NOM_CODE) * PCT_FULL;
   endproperty
   a_setp_full: assert property (p_setp_full) else $error("setpoint full scale out of range");

   property p_sr_load;
      output_current_sense_in < light_load_limit_in |=> supply_status_out[STAT_SR_BIT];
   endproperty
   a_sr_load: assert property (p_sr_load) else $error("light-load rectifier flag missing");

   property p_oring_on;
      oring_switch_on_in |=> !supply_status_out[STAT_ORING_BIT];
   endproperty
   a_oring_on: assert property (p_oring_on) else $error("oring-off flag while switch on");

   property p_commit_armed;
      s_reg.cst != C_ARMED |=> !nv_write_out;
   endproperty
   a_commit_armed: assert property (p_commit_armed) else $error("commit without armed sequence");

   property p_rd_vs23;
      rq.rd && (rq.addr == ADDR_VS2 || rq.addr == ADDR_VS3)
         |=> reg_rvalid_out && reg_rdata_out[RD_LSB-1:0] == '0;
   endproperty
   a_rd_vs23: assert property (p_rd_vs23) else $error("voltage reading low bits set");

   c_commit: cover property (nv_write_out);
   c_off_clear: cover property ($fell(supply_status_out[STAT_OFF_BIT]));
   c_ov1: cover property ($rose(primary_ov_flag_out));
   c_ov3: cover property ($rose(remote_ov_flag_out));
   c_uv1: cover property ($rose(primary_uv_flag_out));
endmodule

/* verification/smp_host_model.sv */
`timescale 1ns/1ns
module smp_host_model
   import smp_pkg::*;
#(
   // the device does not time the settle wait, so it is shortened from 40 ms to keep the run short
   parameter int WAIT_CYC = 64
) (
   input  wire logic        clk_in,
   input  wire logic [15:0] rdata_in,
   input  wire logic        rvalid_in,
   output smp_req_t         req_out
);
   initial req_out = '0;

   // an idle cycle follows every request so a strobe is never raised and dropped in one step
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_in);
      req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge clk_in);
      req_out <= '0;
   endtask

   task automatic read(input logic [7:0] addr, output logic [15:0] data, output logic ok);
      @(posedge clk_in);
      req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge clk_in);
      req_out <= '0;
      #1;
      ok = rvalid_in;
      data = rdata_in;
   endtask

   // in_order low drops the second key, which the device must treat as a broken sequence
   task automatic commit(input logic in_order);
      write(ADDR_KEY, KEY_VAL);
      if (in_order) begin
         write(ADDR_KEY, KEY_VAL);
      end
      write(ADDR_TRIG, KEY_VAL);
      repeat (WAIT_CYC) @(posedge clk_in);
      write(ADDR_KEY, GO_VAL);
   endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top
   import smp_pkg::*;
;
   localparam logic [11:0] NOM = 12'h800;
   logic        clk_in   = 1'b0;
   logic        srst_in  = 1'b1;
   logic [11:0] pv       = 12'h400;
   logic [11:0] sv       = 12'h3a0;
   logic [11:0] rv       = 12'h5c0;
   logic [11:0] oc       = 12'h9a5;
   logic [11:0] load_lim = 12'h100;
   logic        sw_sel   = 1'b1;
   logic        pin      = 1'b0;
   logic        off      = 1'b0;
   logic        oring    = 1'b1;
   logic        sr_user  = 1'b0;
   logic        sr_flag  = 1'b0;
   smp_req_t    req;
   logic [15:0] rdata;
   logic        rvalid;
   logic [7:0]  status;
   logic        pon_req, hs, reso, ov1, ov3, uv1, nvw;
   logic [11:0] sp;
   smp_cfg_t    nv_img;
   logic [15:0] rd_v;
   logic        rd_ok;
   int          n_mismatch   = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   int          nv_pulses    = 0;

   always #4 clk_in = ~clk_in;

   smp_regs #(.NOM_CODE(NOM)) dut_u (
      .clk_in(clk_in), .srst_in(srst_in), .reg_req_in(req),
      .primary_voltage_sense_in(pv), .secondary_voltage_sense_in(sv),
      .remote_voltage_sense_in(rv), .output_current_sense_in(oc),
      .sw_power_on_sel_in(sw_sel), .power_on_pin_in(pin), .supply_off_in(off),
      .oring_switch_on_in(oring), .sr_user_disabled_in(sr_user), .sr_flag_disable_in(sr_flag),
      .light_load_limit_in(load_lim), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .supply_status_out(status), .power_on_request_out(pon_req), .high_side_sense_out(hs),
      .resonant_mode_out(reso), .setpoint_code_out(sp), .primary_ov_flag_out(ov1),
      .remote_ov_flag_out(ov3), .primary_uv_flag_out(uv1), .nv_write_out(nvw),
      .nv_image_out(nv_img)
   );

   smp_host_model #(.WAIT_CYC(64)) host_u (
      .clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req)
   );

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // the limit is far above the few hundred cycles the sequence needs
   always @(posedge clk_in) begin
      cycles++;
      if (nvw === 1'b1) begin
         nv_pulses++;
      end
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic flag(input logic got, input logic exp);
      check({15'h0000, got}, {15'h0000, exp});
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
      host_u.read(a, rd_v, rd_ok);
      flag(rd_ok, 1'b1);
      check(rd_v, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   function automatic logic [15:0] trimmed(input logic [11:0] raw, input int t);
      int v;
      v = (int'(raw) * (256 + t)) / 256;
      return {v[11:0], 4'h0};
   endfunction

   function automatic logic [15:0] setp(input logic [7:0] s);
      int v;
      v = (int'(NOM) * int'(PCT_FULL) * int'(s)) / int'(SET_DEN);
      return {4'h0, v[11:0]};
   endfunction

   initial begin
      settle(5);
      srst_in <= 1'b0;
      settle(3);
      check({8'h00, status}, 16'h0000);
      rd_check(8'h15, trimmed(12'h400, 0));
      rd_check(8'h16, trimmed(12'h3a0, 0));
      rd_check(8'h17, trimmed(12'h5c0, 0));
      rd_check(ADDR_CS, {12'h9a5, 4'h0});
      host_u.write(8'h15, 8'hff);
      host_u.write(ADDR_CS, 8'hff);
      rd_check(8'h15, trimmed(12'h400, 0));
      rd_check(ADDR_CS, {12'h9a5, 4'h0});
      rd_check(8'h7f, 16'h0000);
      host_u.write(ADDR_CSCFG, 8'h80);
      settle(3);
      flag(hs, 1'b1);
      rd_check(ADDR_CSCFG, 16'h0000);
      host_u.write(ADDR_SETP, 8'ha5);
      settle(3);
      check({4'h0, sp}, setp(8'ha5));
      host_u.write(ADDR_TRIM1, 8'h10);
      host_u.write(ADDR_TRIM2, 8'hf0);
      host_u.write(ADDR_TRIM3, 8'h20);
      settle(3);
      rd_check(8'h15, trimmed(12'h400, 16));
      rd_check(8'h16, trimmed(12'h3a0, -16));
      rd_check(8'h17, trimmed(12'h5c0, 32));
      host_u.write(ADDR_SETP, 8'hff);
      settle(3);
      check({4'h0, sp}, setp(8'hff));
      host_u.write(ADDR_TOPO, 8'h01);
      settle(3);
      flag(reso, 1'b1);
      host_u.write(ADDR_TOPO, TOPO_OTHER);
      settle(3);
      flag(reso, 1'b0);
      // sticky supply-off flag, cleared only by a power-on request
      off <= 1'b1;
      settle(3);
      flag(status[STAT_OFF_BIT], 1'b1);
      off <= 1'b0;
      settle(3);
      flag(status[STAT_OFF_BIT], 1'b1);
      host_u.write(ADDR_PON, 8'h20);
      settle(3);
      flag(pon_req, 1'b1);
      flag(status[STAT_OFF_BIT], 1'b0);
      host_u.write(ADDR_PON, 8'h00);
      settle(3);
      flag(pon_req, 1'b0);
      // with software control deselected the pin alone drives the request
      sw_sel <= 1'b0;
      pin <= 1'b1;
      settle(3);
      flag(pon_req, 1'b1);
      pin <= 1'b0;
      settle(3);
      flag(pon_req, 1'b0);
      sw_sel <= 1'b1;
      oring <= 1'b0;
      settle(3);
      flag(status[STAT_ORING_BIT], 1'b1);
      oring <= 1'b1;
      settle(3);
      flag(status[STAT_ORING_BIT], 1'b0);
      for (int k = 0; k < 3; k++) begin
         sr_user <= (k == 0);
         sr_flag <= (k == 1);
         oc <= (k == 2) ? 12'h050 : 12'h9a5;
         settle(3);
         flag(status[STAT_SR_BIT], 1'b1);
         sr_user <= 1'b0;
         sr_flag <= 1'b0;
         oc <= 12'h9a5;
         settle(3);
         flag(status[STAT_SR_BIT], 1'b0);
      end
      // unity trims so threshold comparisons see the raw codes
      host_u.write(ADDR_TRIM1, 8'h00);
      host_u.write(ADDR_TRIM3, 8'h00);
      host_u.write(ADDR_OV1, 8'h11);
      host_u.write(ADDR_OV3, 8'h00);
      settle(1);
      pv <= 12'h8c0;
      settle(24);
      flag(ov1, 1'b0);
      flag(ov3, 1'b0);
      pv <= 12'h900;
      rv <= 12'h8a0;
      settle(4);
      flag(ov1, 1'b0);
      settle(16);
      flag(ov1, 1'b1);
      flag(ov3, 1'b1);
      host_u.write(ADDR_UV1, 8'h40);
      settle(1);
      pv <= 12'h600;
      settle(6);
      flag(uv1, 1'b1);
      pv <= 12'h680;
      settle(6);
      flag(uv1, 1'b0);
      host_u.commit(1'b0);
      settle(3);
      check(16'(nv_pulses), 16'h0000);
      host_u.commit(1'b1);
      settle(3);
      check(16'(nv_pulses), 16'h0001);
      check({8'h00, nv_img.setpoint}, 16'h00ff);
      check({8'h00, nv_img.cs_cfg}, 16'h0080);
      report_and_stop();
   end
endmodule
